/* File: design/apq_params.svh */
// Behaviour
// - servo-ready rises two seconds after power-on, never earlier
// - rs232 command: axis byte equals switch value, companion 2Eh minus value
// - rs485: id 0 refused; address 80h+id, axis id, companion 2Eh minus id
// - each low status bit is one while its error is present
// - reply carries single-turn position and multi-turn count as hex
// - encoder clear resets error state and zeroes multi-turn count
// - incremental encoder flags error as soon as clear starts
// - absolute clear completes within about one second
// - alarm forty or cable loss requires re-initialisation
// - battery alarm cleared by alarm-clear input held over 120 ms
// - frames are 8N1; rs232 full duplex, rs485 half duplex
// - baud codes 0..5 pick 2400..57600, latched at power-on only
`ifndef APQ_PARAMS_SVH
`define APQ_PARAMS_SVH
`define APQ_CLK_HZ 100000000
`define APQ_READY_MS 2000
`define APQ_CLEAR_MS 1000
`define APQ_ACLR_MS 120
`define APQ_REPLY_LEN 15
`define APQ_CMD_LEN 3
`define APQ_COMP_BASE 8'h2E
`define APQ_ADDR_BASE 8'h80
`define APQ_CMD_QUERY 8'h41
`define APQ_BAUD_MAX 3'h5
`define APQ_BAUD_DIV0 41667
`define APQ_BAUD_TOP_MUL 24
`endif

/* File: design/apq_pkg.sv */
package apq_pkg;
  typedef enum logic [4:0] {
    APQ_IDLE = 5'b00001,
    APQ_RX = 5'b00010,
    APQ_LOAD = 5'b00100,
    APQ_TX = 5'b01000,
    APQ_WAIT = 5'b10000
  } apq_state_t;
endpackage

/* File: design/apq_top.sv */
`timescale 1ns/1ps
`include "apq_params.svh"
// absolute position query port: answers one query with a 15-byte reply
module apq_top
  import apq_pkg::*;
#(
  parameter int READY_CYC = `APQ_CLK_HZ / 1000 * `APQ_READY_MS,
  parameter int CLEAR_CYC = `APQ_CLK_HZ / 1000 * `APQ_CLEAR_MS,
  parameter int ACLR_CYC = `APQ_CLK_HZ / 1000 * `APQ_ACLR_MS,
  parameter int BAUD_DIV0 = `APQ_BAUD_DIV0
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // straps sampled once after reset
  input wire logic [3:0] rotary_id_switch_i,
  input wire logic rs485_sel_i,
  input wire logic [2:0] rs232_baud_code_i,
  input wire logic [2:0] rs485_baud_code_i,
  // encoder side
  input wire logic [16:0] single_turn_i,
  input wire logic [7:0] enc_err_i,
  input wire logic rev_up_i,
  input wire logic rev_dn_i,
  input wire logic incremental_i,
  input wire logic clear_req_i,
  input wire logic abs_down_i,
  input wire logic cable_lost_i,
  input wire logic battery_alarm_set_i,
  input wire logic alarm_clear_input_b_i,
  // serial link
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_oe_o,
  // status
  output logic servo_ready_o,
  output logic clear_error_o,
  output logic clear_done_o,
  output logic init_needed_o,
  output logic battery_alarm_o,
  output logic [15:0] multi_turn_o
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] rx_s, aclr_s, clr_s;
  logic rx_q;
  // reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];
  // pin synchronisers; only the second stage is used
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s <= 2'b11;
      aclr_s <= 2'b11;
      clr_s <= 2'b00;
    end
    else
    begin
      rx_s <= {rx_s[0], rx_i};
      aclr_s <= {aclr_s[0], alarm_clear_input_b_i};
      clr_s <= {clr_s[0], clear_req_i};
    end
  end
  assign rx_q = rx_s[1];

  // strap and timer state
  logic strapped_reg, strapped_next;
  logic [3:0] id_reg, id_next;
  logic mode485_reg, mode485_next;
  logic [15:0] div_reg, div_next;
  logic [31:0] rdy_cnt_reg, rdy_cnt_next;
  logic rdy_reg, rdy_next;
  logic [31:0] clr_cnt_reg, clr_cnt_next;
  logic clr_busy_reg, clr_busy_next, clr_err_reg, clr_err_next, clr_done_reg, clr_done_next;
  logic clr_q_reg, clr_q_next;
  logic [15:0] mt_reg, mt_next;
  logic [7:0] err_mask_reg, err_mask_next;
  logic init_reg, init_next;
  logic [31:0] ac_cnt_reg, ac_cnt_next;
  logic batt_reg, batt_next;
  logic [2:0] code;

  // baud codes 0..4 double 2400 per step, code 5 is 57600
  always_comb
  begin
    strapped_next = 1'b1;
    id_next = id_reg;
    mode485_next = mode485_reg;
    div_next = div_reg;
    code = rs485_sel_i ? rs485_baud_code_i : rs232_baud_code_i;
    if (code > `APQ_BAUD_MAX)
      code = `APQ_BAUD_MAX;
    if (!strapped_reg)
    begin
      id_next = rotary_id_switch_i; // latched only at power-on
      mode485_next = rs485_sel_i;
      if (code == `APQ_BAUD_MAX)
        div_next = 16'(BAUD_DIV0 / `APQ_BAUD_TOP_MUL - 1); // top rate is 24x base, not 32x
      else
        div_next = 16'((BAUD_DIV0 >> code) - 1);
    end
    // ready after two seconds
    rdy_cnt_next = rdy_cnt_reg;
    rdy_next = rdy_reg;
    if (rdy_cnt_reg == 32'(READY_CYC - 1))
      rdy_next = 1'b1;
    else
      rdy_cnt_next = rdy_cnt_reg + 32'h1;
    // encoder clear sequence
    clr_q_next = clr_s[1];
    clr_cnt_next = clr_cnt_reg;
    clr_busy_next = clr_busy_reg;
    clr_err_next = clr_err_reg;
    clr_done_next = clr_done_reg;
    mt_next = mt_reg;
    err_mask_next = err_mask_reg;
    init_next = init_reg | abs_down_i | cable_lost_i;
    if (rev_up_i && !rev_dn_i)
      mt_next = mt_reg + 16'h0001;
    else if (rev_dn_i && !rev_up_i)
      mt_next = mt_reg - 16'h0001;
    if (clr_s[1] && !clr_q_reg && !clr_busy_reg)
    begin
      if (incremental_i)
        clr_err_next = 1'b1;
      else
      begin
        clr_busy_next = 1'b1;
        clr_err_next = 1'b0;
        clr_done_next = 1'b0;
        clr_cnt_next = 32'h0;
      end
    end
    else if (clr_busy_reg)
    begin
      if (clr_cnt_reg == 32'(CLEAR_CYC - 1))
      begin
        clr_busy_next = 1'b0;
        clr_done_next = 1'b1;
        mt_next = 16'h0000;
        err_mask_next = 8'h00;
        init_next = abs_down_i | cable_lost_i;
      end
      else
        clr_cnt_next = clr_cnt_reg + 32'h1;
    end
    // battery alarm, cleared by long low on clear input
    ac_cnt_next = aclr_s[1] ? 32'h0 : ac_cnt_reg;
    batt_next = batt_reg | battery_alarm_set_i;
    if (!aclr_s[1])
    begin
      if (ac_cnt_reg == 32'(ACLR_CYC))
        batt_next = battery_alarm_set_i; // set wins
      else
        ac_cnt_next = ac_cnt_reg + 32'h1;
    end
    // error state latches until an encoder clear; a live error wins over the clear
    err_mask_next = err_mask_next | enc_err_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strapped_reg <= 1'b0;
      id_reg <= 4'h0;
      mode485_reg <= 1'b0;
      div_reg <= 16'hFFFF;
      rdy_cnt_reg <= 32'h0;
      rdy_reg <= 1'b0;
      clr_cnt_reg <= 32'h0;
      clr_busy_reg <= 1'b0;
      clr_err_reg <= 1'b0;
      clr_done_reg <= 1'b0;
      clr_q_reg <= 1'b0;
      mt_reg <= 16'h0000;
      err_mask_reg <= 8'h00;
      init_reg <= 1'b0;
      ac_cnt_reg <= 32'h0;
      batt_reg <= 1'b0;
    end
    else
    begin
      strapped_reg <= strapped_next;
      id_reg <= id_next;
      mode485_reg <= mode485_next;
      div_reg <= div_next;
      rdy_cnt_reg <= rdy_cnt_next;
      rdy_reg <= rdy_next;
      clr_cnt_reg <= clr_cnt_next;
      clr_busy_reg <= clr_busy_next;
      clr_err_reg <= clr_err_next;
      clr_done_reg <= clr_done_next;
      clr_q_reg <= clr_q_next;
      mt_reg <= mt_next;
      err_mask_reg <= err_mask_next;
      init_reg <= init_next;
      ac_cnt_reg <= ac_cnt_next;
      batt_reg <= batt_next;
    end
  end

  // serial engine
  logic rx_vld, tx_busy, tx_go_reg, tx_go_next, tx_line;
  logic [7:0] rx_dat, tx_dat_reg, tx_dat_next;
  apq_uart u_uart
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .div_i(div_reg),
    .rx_i(rx_q),
    .tx_o(tx_line),
    .rx_vld_o(rx_vld),
    .rx_dat_o(rx_dat),
    .tx_go_i(tx_go_reg),
    .tx_dat_i(tx_dat_reg),
    .tx_busy_o(tx_busy)
  );

  // command match and reply sequencing
  apq_state_t st_reg, st_next;
  logic [1:0] cidx_reg, cidx_next;
  logic [3:0] ridx_reg, ridx_next;
  logic [7:0] sum_reg, sum_next;
  logic [59:0] snap_reg, snap_next;
  logic [7:0] exp_byte, nib;
  logic [7:0] tx_q_reg, tx_oe_reg, cr;

  // expected command bytes per mode
  always_comb
  begin
    exp_byte = `APQ_CMD_QUERY;
    if (cidx_reg == 2'd0)
      exp_byte = mode485_reg ? (`APQ_ADDR_BASE | {4'h0, id_reg}) : {4'h0, id_reg};
    else if (cidx_reg == 2'd1)
      exp_byte = mode485_reg ? {4'h0, id_reg} : `APQ_COMP_BASE - {4'h0, id_reg};
    else if (cidx_reg == 2'd2)
      exp_byte = mode485_reg ? `APQ_COMP_BASE - {4'h0, id_reg} : `APQ_CMD_QUERY;
  end

  // reply: 14 hex characters of status, turns, position, then checksum
  always_comb
  begin
    nib = {4'h0, snap_reg[59:56]};
    cr = (nib < 8'h0A) ? nib + 8'h30 : nib + 8'h37;
    st_next = st_reg;
    cidx_next = cidx_reg;
    ridx_next = ridx_reg;
    sum_next = sum_reg;
    snap_next = snap_reg;
    tx_go_next = 1'b0;
    tx_dat_next = tx_dat_reg;
    case (st_reg)
      APQ_IDLE:
      begin
        cidx_next = 2'd0;
        if (mode485_reg && id_reg == 4'h0)
          st_next = APQ_IDLE; // id 0 never answers on rs485
        else if (rx_vld && rdy_reg)
          st_next = APQ_RX;
      end
      APQ_RX:
      begin
        if (cidx_reg == 2'd0 && rx_dat != exp_byte)
          st_next = APQ_IDLE;
        else
        begin
          st_next = APQ_WAIT;
          if (rx_dat != exp_byte)
            st_next = APQ_IDLE;
          else if (cidx_reg == 2'(`APQ_CMD_LEN - 1))
            st_next = APQ_LOAD;
          cidx_next = cidx_reg + 2'd1;
        end
      end
      APQ_WAIT:
        if (rx_vld)
          st_next = APQ_RX;
      APQ_LOAD:
      begin
        snap_next = {4'h0, err_mask_reg | enc_err_i, mt_reg, 7'h00, single_turn_i, 8'h00};
        ridx_next = 4'h0;
        sum_next = 8'h00;
        st_next = APQ_TX;
      end
      APQ_TX:
        if (!tx_busy && !tx_go_reg)
        begin
          tx_go_next = 1'b1;
          ridx_next = ridx_reg + 4'h1;
          if (ridx_reg == 4'(`APQ_REPLY_LEN - 1))
          begin
            tx_dat_next = 8'h00 - sum_reg; // sum of all 15 becomes zero
            st_next = APQ_IDLE;
          end
          else
          begin
            tx_dat_next = cr;
            sum_next = sum_reg + cr;
            snap_next = {snap_reg[55:0], 4'h0};
          end
        end
      default:
        st_next = APQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= APQ_IDLE;
      cidx_reg <= 2'd0;
      ridx_reg <= 4'h0;
      sum_reg <= 8'h00;
      snap_reg <= 60'h0;
      tx_go_reg <= 1'b0;
      tx_dat_reg <= 8'h00;
      tx_q_reg <= 8'hFF;
      tx_oe_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      cidx_reg <= cidx_next;
      ridx_reg <= ridx_next;
      sum_reg <= sum_next;
      snap_reg <= snap_next;
      tx_go_reg <= tx_go_next;
      tx_dat_reg <= tx_dat_next;
      tx_q_reg <= {7'h7F, tx_line};
      // state term keeps the driver on in the gap between reply bytes
      tx_oe_reg <= {7'h00, !mode485_reg || tx_busy || tx_go_reg || st_reg == APQ_TX}; // half duplex drive
    end
  end

  assign tx_o = tx_q_reg[0];
  assign tx_oe_o = tx_oe_reg[0];
  assign servo_ready_o = rdy_reg;
  assign clear_error_o = clr_err_reg;
  assign clear_done_o = clr_done_reg;
  assign init_needed_o = init_reg;
  assign battery_alarm_o = batt_reg;
  assign multi_turn_o = mt_reg;

  // checks
  property p_ready_late;
    @(posedge mclk_i) disable iff (!rst_n) (rdy_cnt_reg < 32'(READY_CYC - 1)) |-> !rdy_reg;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  property p_ready_hold;
    @(posedge mclk_i) disable iff (!rst_n) rdy_reg |=> rdy_reg;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  property p_incr_err;
    @(posedge mclk_i) disable iff (!rst_n) (clr_s[1] && !clr_q_reg && !clr_busy_reg && incremental_i) |=> clr_err_reg;
  endproperty
  a_incr_err: assert property (p_incr_err) else $error("no clear error");
  property p_clear_zero;
    @(posedge mclk_i) disable iff (!rst_n) $rose(clr_done_reg) |-> mt_reg == 16'h0000;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("turns not zeroed");
  property p_clear_time;
    @(posedge mclk_i) disable iff (!rst_n) clr_busy_reg |-> clr_cnt_reg < 32'(CLEAR_CYC);
  endproperty
  a_clear_time: assert property (p_clear_time) else $error("clear too long");
  property p_batt_short;
    @(posedge mclk_i) disable iff (!rst_n) (batt_reg && ac_cnt_reg < 32'(ACLR_CYC)) |=> batt_reg;
  endproperty
  a_batt_short: assert property (p_batt_short) else $error("alarm cleared early");
  property p_id0;
    @(posedge mclk_i) disable iff (!rst_n) (mode485_reg && id_reg == 4'h0 && strapped_reg) |-> st_reg == APQ_IDLE;
  endproperty
  a_id0: assert property (p_id0) else $error("id 0 answered");
  property p_init;
    @(posedge mclk_i) disable iff (!rst_n) (abs_down_i && !clr_busy_reg) |=> init_reg;
  endproperty
  a_init: assert property (p_init) else $error("init not flagged");
  c_reply: cover property (@(posedge mclk_i) disable iff (!rst_n) st_reg == APQ_LOAD);
  c_clear: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(clr_done_reg));
  c_batt: cover property (@(posedge mclk_i) disable iff (!rst_n) $fell(batt_reg));
endmodule

/* File: design/apq_uart.sv */
`timescale 1ns/1ps
`include "apq_params.svh"
// 8n1 serial byte engine, divider fixed at power-on
module apq_uart
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // bit period in clocks, minus one
  input wire logic [15:0] div_i,
  // serial pins, rx already synchronised
  input wire logic rx_i,
  output logic tx_o,
  // byte streams
  output logic rx_vld_o,
  output logic [7:0] rx_dat_o,
  input wire logic tx_go_i,
  input wire logic [7:0] tx_dat_i,
  output logic tx_busy_o
);
  logic [15:0] rcnt_reg, rcnt_next, tcnt_reg, tcnt_next;
  logic [3:0] rbit_reg, rbit_next, tbit_reg, tbit_next;
  logic [8:0] rsh_reg, rsh_next;
  logic [9:0] tsh_reg, tsh_next;
  logic rvld_reg, rvld_next;

  // receiver samples mid-bit; transmitter shifts start, 8 data, stop
  always_comb
  begin
    rcnt_next = rcnt_reg;
    rbit_next = rbit_reg;
    rsh_next = rsh_reg;
    rvld_next = 1'b0;
    tcnt_next = tcnt_reg;
    tbit_next = tbit_reg;
    tsh_next = tsh_reg;
    if (rbit_reg == 4'h0)
    begin
      if (!rx_i)
      begin
        rbit_next = 4'hA;
        rcnt_next = div_i >> 1;
      end
    end
    else if (rcnt_reg != 16'h0000)
      rcnt_next = rcnt_reg - 16'h0001;
    else
    begin
      rcnt_next = div_i;
      rsh_next = {rx_i, rsh_reg[8:1]};
      rbit_next = rbit_reg - 4'h1;
      if (rbit_reg == 4'h1)
        rvld_next = rx_i; // drop frames without stop bit
      if (rbit_reg == 4'hA && rx_i)
        rbit_next = 4'h0; // glitch, not a start bit
    end
    if (tbit_reg == 4'h0)
    begin
      if (tx_go_i)
      begin
        tsh_next = {1'b1, tx_dat_i, 1'b0};
        tbit_next = 4'hA;
        tcnt_next = div_i;
      end
    end
    else if (tcnt_reg != 16'h0000)
      tcnt_next = tcnt_reg - 16'h0001;
    else
    begin
      tcnt_next = div_i;
      tsh_next = {1'b1, tsh_reg[9:1]};
      tbit_next = tbit_reg - 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rcnt_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg <= 9'h1FF;
      rvld_reg <= 1'b0;
      tcnt_reg <= 16'h0000;
      tbit_reg <= 4'h0;
      tsh_reg <= 10'h3FF;
    end
    else
    begin
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rsh_reg <= rsh_next;
      rvld_reg <= rvld_next;
      tcnt_reg <= tcnt_next;
      tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
    end
  end

  assign tx_o = tsh_reg[0];
  assign rx_vld_o = rvld_reg;
  // start bit has fallen off the bottom, stop bit sits in bit 8
  assign rx_dat_o = rsh_reg[7:0];
  assign tx_busy_o = (tbit_reg != 4'h0);
endmodule

/* File: tb/apq_host.sv */
`timescale 1ns/1ps
// host controller model: 8n1 byte sender and receiver on the serial pins
module apq_host
#(
  parameter int BIT_CYC = 1302
)
(
  // clock
  input wire logic mclk_i,
  // serial pins, device side tx and rx
  input wire logic line_i,
  output logic line_o
);
  // idle line is high between frames
  initial line_o = 1'b1;

  // start bit, eight data bits lsb first, one stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk_i);
      line_o <= frame[i];
      repeat (BIT_CYC - 1) @(posedge mclk_i);
    end
  endtask

  // bounded wait for the start bit, then sample mid-bit
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    // long enough to span a command byte still going out
    while (line_i !== 1'b0 && n < 12 * BIT_CYC)
    begin
      @(posedge mclk_i);
      n++;
    end
    ok = (line_i === 1'b0);
    if (ok)
    begin
      repeat (BIT_CYC / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge mclk_i);
        b[i] = line_i;
      end
      repeat (BIT_CYC) @(posedge mclk_i);
      ok = (line_i === 1'b1);
    end
  endtask
endmodule

/* File: tb/apq_top_tb.sv */
`timescale 1ns/1ps
module apq_top_tb;
  localparam int READY = 200;
  localparam int CLR = 100;
  localparam int ACLR = 12;
  localparam int LIMIT = 40000;
  // shortened 2400 bit period; code 5 is 57600, 24 times the base rate
  localparam int BAUD0 = 480;
  localparam int BIT = BAUD0 / 24;
  // stands in for the half-second axis switch gap
  localparam int AXIS_GAP = 50;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [16:0] single_turn_i = 17'h1ABCD;
  logic [7:0] enc_err_i = 8'hA5;
  logic rev_up_i = 1'b0;
  logic rev_dn_i = 1'b0;
  logic incremental_i = 1'b0;
  logic clear_req_i = 1'b0;
  logic abs_down_i = 1'b0;
  logic cable_lost_i = 1'b0;
  logic bat_set_i = 1'b0;
  logic aclr_b_i = 1'b1;
  logic [3:0] id_sw = 4'h3;
  logic sel485 = 1'b0;
  logic rx_w;
  logic tx_o, tx_oe_o, servo_ready_o, clear_error_o, clear_done_o, init_needed_o, battery_alarm_o;
  logic [15:0] multi_turn_o;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;

  // 100 mhz clock
  initial forever #5 mclk_i = ~mclk_i;

  // straps start as rs232 axis 3; fastest baud code on both links
  apq_top #(.READY_CYC(READY), .CLEAR_CYC(CLR), .ACLR_CYC(ACLR), .BAUD_DIV0(BAUD0)) i_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .rotary_id_switch_i(id_sw), .rs485_sel_i(sel485),
    .rs232_baud_code_i(3'h5), .rs485_baud_code_i(3'h5), .single_turn_i(single_turn_i),
    .enc_err_i(enc_err_i), .rev_up_i(rev_up_i), .rev_dn_i(rev_dn_i), .incremental_i(incremental_i),
    .clear_req_i(clear_req_i), .abs_down_i(abs_down_i), .cable_lost_i(cable_lost_i),
    .battery_alarm_set_i(bat_set_i), .alarm_clear_input_b_i(aclr_b_i), .rx_i(rx_w), .tx_o(tx_o),
    .tx_oe_o(tx_oe_o), .servo_ready_o(servo_ready_o), .clear_error_o(clear_error_o),
    .clear_done_o(clear_done_o), .init_needed_o(init_needed_o), .battery_alarm_o(battery_alarm_o),
    .multi_turn_o(multi_turn_o));

  // host bit period matches the divider at code 5
  apq_host #(.BIT_CYC(BIT)) i_host (.mclk_i(mclk_i), .line_i(tx_o), .line_o(rx_w));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      miscompares++;
      test_done();
    end
  end

  function automatic logic [3:0] hex(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return 4'(c - 8'h30);
    if (c >= 8'h41 && c <= 8'h46) return 4'(c - 8'h37);
    if (c >= 8'h61 && c <= 8'h66) return 4'(c - 8'h57);
    return 4'hx;
  endfunction

  // ready must not rise early, and must be up soon after
  task automatic t_ready();
    repeat (READY - 3) @(posedge mclk_i);
    check("ready early", servo_ready_o, 1'b0);
    repeat (9) @(posedge mclk_i);
    check("ready late", servo_ready_o, 1'b1);
    check("rs232 drive", tx_oe_o, 1'b1);
    $display("test ready done");
  endtask

  // three up, five down gives minus two
  task automatic t_turns();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk_i);
      rev_up_i <= (i < 3);
      rev_dn_i <= (i >= 3);
      @(posedge mclk_i);
      rev_up_i <= 1'b0;
      rev_dn_i <= 1'b0;
    end
    repeat (3) @(posedge mclk_i);
    check("multi turn", multi_turn_o, 16'hFFFE);
    $display("test turns done");
  endtask

  // reply starts inside the last command stop bit, so listening runs beside it; bad replies are asked again
  task automatic query(input logic [23:0] cmd, output logic [55:0] word, output logic good);
    logic [7:0] r;
    logic [7:0] sum;
    logic ok;
    good = 1'b0;
    word = 56'h0;
    for (int a = 0; a < 2 && !good; a++)
    begin
      sum = 8'h00;
      word = 56'h0;
      good = 1'b1;
      i_host.send_byte(cmd[23:16]);
      i_host.send_byte(cmd[15:8]);
      fork
        i_host.send_byte(cmd[7:0]);
        for (int i = 0; i < 15; i++)
        begin
          i_host.recv_byte(r, ok);
          good = good & ok;
          sum = sum + r;
          if (i < 14)
            word = {word[51:0], hex(r)};
        end
      join
      good = good & (sum == 8'h00);
    end
  endtask

  // rs232 query to axis 3 once ready, asked twice so both answers can be compared
  task automatic t_query();
    logic [55:0] w1, w2, want;
    logic g1, g2;
    int t;
    want = {4'h0, 8'hA5, 16'hFFFE, 7'h00, 17'h1ABCD, 4'h0};
    query({8'h03, 8'h2B, 8'h41}, w1, g1);
    query({8'h03, 8'h2B, 8'h41}, w2, g2);
    check("reply good", g1 && g2, 1'b1);
    check("reply word", w1, want);
    check("reply repeat", w2, want);
    t = int'(w1[43:28]);
    if (t >= 32768) t -= 65536;
    check("signed turns", t == -2, 1'b1);
    $display("test query done");
  endtask

  // power cycle with new straps; they are latched at the first edge after the two-flop synchronised reset releases
  task automatic power_cycle(input logic sel, input logic [3:0] id);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    sel485 <= sel;
    id_sw <= id;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (READY + 5) @(posedge mclk_i);
  endtask

  // rs485 axis 5 after its own power cycle, then axis 0 which must stay silent
  task automatic t_rs485();
    logic [55:0] w;
    logic g;
    single_turn_i <= 17'h04321;
    enc_err_i <= 8'h12;
    power_cycle(1'b1, 4'h5);
    check("rs485 idle drive", tx_oe_o, 1'b0);
    repeat (AXIS_GAP) @(posedge mclk_i);
    query({8'h85, 8'h05, 8'h29}, w, g);
    check("rs485 reply good", g, 1'b1);
    check("rs485 word", w, {4'h0, 8'h12, 16'h0000, 7'h00, 17'h04321, 4'h0});
    check("rs485 reply drive", tx_oe_o, 1'b1);
    repeat (2 * BIT) @(posedge mclk_i);
    check("rs485 release", tx_oe_o, 1'b0);
    power_cycle(1'b1, 4'h0);
    query({8'h80, 8'h00, 8'h2E}, w, g);
    check("id 0 silent", g, 1'b0);
    check("id 0 no drive", tx_oe_o, 1'b0);
    $display("test rs485 done");
  endtask

  // raise a clear request and wait for completion or error
  task automatic do_clear(input int lim);
    @(posedge mclk_i);
    clear_req_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    clear_req_i <= 1'b0;
    for (int n = 0; n < lim && clear_done_o !== 1'b1 && clear_error_o !== 1'b1; n++)
      @(posedge mclk_i);
  endtask

  task automatic t_clear();
    @(posedge mclk_i);
    abs_down_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    abs_down_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    check("init after alarm", init_needed_o, 1'b1);
    do_clear(CLR + 20);
    check("clear done", clear_done_o, 1'b1);
    check("clear turns", multi_turn_o, 16'h0000);
    check("init cleared", init_needed_o, 1'b0);
    cable_lost_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    cable_lost_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    check("init after cable", init_needed_o, 1'b1);
    incremental_i <= 1'b1;
    do_clear(8);
    check("incremental error", clear_error_o, 1'b1);
    $display("test clear done");
  endtask

  // short clear pulse ignored, long one clears
  task automatic t_battery();
    @(posedge mclk_i);
    bat_set_i <= 1'b1;
    @(posedge mclk_i);
    bat_set_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("alarm set", battery_alarm_o, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      aclr_b_i <= 1'b0;
      repeat (k ? ACLR + 4 : ACLR - 4) @(posedge mclk_i);
      aclr_b_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check("alarm after clear", battery_alarm_o, 1'(k == 0));
    end
    $display("test battery done");
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_ready();
    t_turns();
    t_query();
    t_clear();
    t_battery();
    t_rs485();
    test_done();
  end
endmodule
